// [epc_pkg.sv]
// Package with register map, field layout and timing constants of the array programming control
package epc_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses on APB)
    // ----------------------------------------------------------------
    localparam logic [11:0] EPC_IDX_PROGRAM_CONTROL  = 12'h01E; // Word index of the control register
    localparam logic [11:0] EPC_ADDR_PROGRAM_CONTROL =
        {EPC_IDX_PROGRAM_CONTROL[9:0], 2'b00};                  // Byte address, four times the index
    localparam logic [11:0] EPC_ADDR_STATUS          = 12'h100;
    localparam logic [11:0] EPC_ADDR_ARRAY_ADDR      = 12'h104;
    localparam logic [11:0] EPC_ADDR_ARRAY_DATA      = 12'h108;
    localparam logic [11:0] EPC_ADDR_ARRAY_WINDOW    = 12'h800; // Array window base
    localparam int          EPC_ARRAY_AW             = 11;      // Window: 2k byte addresses on APB, one array byte each
    localparam logic [7:0]  EPC_CTRL_RESET           = 8'h00;
    localparam int          EPC_BIT_LATCH            = 1;
    localparam int          EPC_BIT_POWER            = 0;
    localparam logic [7:0]  EPC_CTRL_WMASK           = 8'h03;

    // ----------------------------------------------------------------
    // Bootloader ROM range and timing
    // ----------------------------------------------------------------
    localparam logic [15:0] EPC_BOOT_ROM_LO      = 16'h1E00;
    localparam logic [15:0] EPC_BOOT_ROM_HI      = 16'h1FEF;
    localparam int          EPC_CLK_HZ           = 25000000;
    localparam int          EPC_BYTE_PROG_TIME_US = 1000;   // Byte program time, 1 ms
    localparam int          EPC_BYTE_PROG_CYCLES =
        (EPC_CLK_HZ / 1000000) * EPC_BYTE_PROG_TIME_US;     // Least time, exact here

    // Array side outputs travel together
    typedef struct packed {
        logic        read_enable;
        logic        latch_mode;
        logic        program_power;
        logic [15:0] addr;
        logic [7:0]  data;
    } epc_array_t;

    typedef enum logic [1:0] {
        EPC_BOOT_IDLE   = 2'b00,
        EPC_BOOT_ACTIVE = 2'b01
    } epc_boot_t;

endpackage

// [epc_program_control.sv]
// Array programming control register block with APB slave and bootloader entry
//
// Overview of operation
// - Bootloader mode entered at reset release when test voltage and port B bit high.
// - Bootloader code lives in masked ROM from 1E00 to 1FEF.
// - Bootloader copies user code from external memory into the array only.
// - Bootloader programs each byte for 1 ms, then runs a verify pass.
// - Control register sits at 001E and alone controls array programming.
// - Latch bit clear sets array paths to ordinary read access.
// - Latch bit set makes array writes capture address and data into latches.
// - Latch bit set makes array reads return no valid data.
// - Power bit clear removes programming power from the array.
// - Power bit set applies power; forced clear when latch bit is clear.
//
// The APB register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module epc_program_control
    import epc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        test_level_voltage,
    input  wire logic        port_b_bit_zero_pin,
    input  wire logic [7:0]  array_rdata,
    output epc_array_t       array_ctl,
    output logic             bootloader_mode,
    output logic             boot_rom_select
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] tst_sync_reg;
    logic [1:0] pb0_sync_reg;

    // Two flops per pin; only the second stage is read by logic
    always_ff @(posedge clk) begin
        tst_sync_reg <= {tst_sync_reg[0], test_level_voltage};
        pb0_sync_reg <= {pb0_sync_reg[0], port_b_bit_zero_pin};
    end

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic in_window(input logic [11:0] a);
        in_window = (a[11] == EPC_ADDR_ARRAY_WINDOW[11]);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = in_window(a) || (a == EPC_ADDR_PROGRAM_CONTROL)
                    || (a == EPC_ADDR_STATUS) || (a == EPC_ADDR_ARRAY_ADDR)
                    || (a == EPC_ADDR_ARRAY_DATA);
    endfunction

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic        latch_mode_bit_reg,    latch_mode_bit_next;
    logic        program_power_bit_reg, program_power_bit_next;
    logic [15:0] lat_addr_reg,          lat_addr_next;
    logic [7:0]  lat_data_reg,          lat_data_next;
    logic [31:0] prdata_reg,            prdata_next;
    logic        pready_reg,            pready_next;
    logic        pslverr_reg,           pslverr_next;
    logic        reset_seen_reg,        reset_seen_next;
    epc_boot_t   boot_reg,              boot_next;
    epc_array_t  array_reg,             array_next;
    logic [15:0] boot_cnt_reg,          boot_cnt_next;

    wire logic setup_phase = psel && !penable;
    wire logic wr_take     = psel && penable && pready_reg && pwrite;
    wire logic rd_setup    = setup_phase && !pwrite;
    wire logic win_rd_setup = rd_setup && in_window(paddr);
    wire logic win_rd_wait  = psel && penable && !pwrite && !pready_reg && in_window(paddr);

    // Next state of bus and control registers
    always_comb begin
        latch_mode_bit_next    = latch_mode_bit_reg;
        program_power_bit_next = program_power_bit_reg;
        lat_addr_next          = lat_addr_reg;
        lat_data_next          = lat_data_reg;
        prdata_next            = prdata_reg;
        pslverr_next           = 1'b0;
        pready_next            = (setup_phase && !win_rd_setup) || win_rd_wait; // Array reads wait once
        reset_seen_next        = 1'b1;
        boot_next              = boot_reg;
        boot_cnt_next          = boot_cnt_reg;

        // Bootloader entry sampled on the first edge after reset release
        if (!reset_seen_reg) begin
            if (tst_sync_reg[1] && pb0_sync_reg[1]) begin
                boot_next = EPC_BOOT_ACTIVE;
            end
        end

        // Byte program timer used for the bootloader pass
        if (boot_reg == EPC_BOOT_ACTIVE && program_power_bit_reg) begin
            if (boot_cnt_reg != 16'(EPC_BYTE_PROG_CYCLES)) begin
                boot_cnt_next = boot_cnt_reg + 16'h0001;
            end
        end else begin
            boot_cnt_next = 16'h0000;
        end

        // Register writes
        if (wr_take) begin
            if (paddr == EPC_ADDR_PROGRAM_CONTROL) begin
                latch_mode_bit_next    = pwdata[EPC_BIT_LATCH];
                program_power_bit_next = pwdata[EPC_BIT_POWER]
                                         && pwdata[EPC_BIT_LATCH];
            end else if (in_window(paddr) && latch_mode_bit_reg) begin
                lat_addr_next = 16'(paddr[EPC_ARRAY_AW-1:0]);
                lat_data_next = pwdata[7:0];
            end
            pslverr_next = !is_mapped(paddr) && pready_reg;
        end else if (setup_phase && !is_mapped(paddr)) begin
            pslverr_next = 1'b1;
        end
        if (setup_phase && pwrite) begin
            pslverr_next = !is_mapped(paddr);
        end

        // Read data captured in the setup phase
        if (rd_setup) begin
            prdata_next = 32'h0000_0000;
            if (paddr == EPC_ADDR_PROGRAM_CONTROL) begin
                prdata_next[EPC_BIT_LATCH] = latch_mode_bit_reg;
                prdata_next[EPC_BIT_POWER] = program_power_bit_reg;
            end else if (paddr == EPC_ADDR_STATUS) begin
                prdata_next[0] = (boot_reg == EPC_BOOT_ACTIVE);
                prdata_next[1] = (boot_cnt_reg == 16'(EPC_BYTE_PROG_CYCLES));
            end else if (paddr == EPC_ADDR_ARRAY_ADDR) begin
                prdata_next[15:0] = lat_addr_reg;
            end else if (paddr == EPC_ADDR_ARRAY_DATA) begin
                prdata_next[7:0] = lat_data_reg;
            end
        end

        // Array read data taken once the registered array address has settled
        if (win_rd_wait) begin
            if (!latch_mode_bit_reg) begin
                prdata_next[7:0] = array_rdata;
            end else begin
                prdata_next[7:0] = 8'h00;
            end
        end
        if (!setup_phase) begin
            pslverr_next = pslverr_reg && 1'b0;
        end
    end

    // Array side outputs: read path or programming latches
    always_comb begin
        array_next               = '0;
        array_next.latch_mode    = latch_mode_bit_next;
        array_next.program_power = program_power_bit_next && latch_mode_bit_next;
        array_next.read_enable   = !latch_mode_bit_next;
        if (latch_mode_bit_next) begin
            array_next.addr = lat_addr_next;
            array_next.data = lat_data_next;
        end else begin
            array_next.addr = 16'(paddr[EPC_ARRAY_AW-1:0]);
            array_next.data = 8'h00;
        end
    end

    // Register all state except the pin synchronisers
    always_ff @(posedge clk) begin
        if (reset) begin
            latch_mode_bit_reg    <= EPC_CTRL_RESET[EPC_BIT_LATCH];
            program_power_bit_reg <= EPC_CTRL_RESET[EPC_BIT_POWER];
            lat_addr_reg          <= 16'h0000;
            lat_data_reg          <= 8'h00;
            prdata_reg            <= 32'h0000_0000;
            pready_reg            <= 1'b0;
            pslverr_reg           <= 1'b0;
            reset_seen_reg        <= 1'b0;
            boot_reg              <= EPC_BOOT_IDLE;
            boot_cnt_reg          <= 16'h0000;
            array_reg             <= '{read_enable: 1'b1, latch_mode: 1'b0, program_power: 1'b0,
                                       addr: 16'h0000, data: 8'h00}; // Read path open
        end else begin
            latch_mode_bit_reg    <= latch_mode_bit_next;
            program_power_bit_reg <= program_power_bit_next;
            lat_addr_reg          <= lat_addr_next;
            lat_data_reg          <= lat_data_next;
            prdata_reg            <= prdata_next;
            pready_reg            <= pready_next;
            pslverr_reg           <= pslverr_next;
            reset_seen_reg        <= reset_seen_next;
            boot_reg              <= boot_next;
            boot_cnt_reg          <= boot_cnt_next;
            array_reg             <= array_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata          = prdata_reg;
    assign pready          = pready_reg;
    assign pslverr         = pslverr_reg;
    assign array_ctl       = array_reg;
    assign bootloader_mode = (boot_reg == EPC_BOOT_ACTIVE);
    assign boot_rom_select = (boot_reg == EPC_BOOT_ACTIVE);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_power_needs_latch: assert property (@(posedge clk) disable iff (reset)
        program_power_bit_reg |-> latch_mode_bit_reg)
        else $error("Power bit set without latch bit");

    a_power_off_out: assert property (@(posedge clk) disable iff (reset)
        !program_power_bit_reg |-> !array_reg.program_power)
        else $error("Array power on while power bit clear");

    a_latch_capture: assert property (@(posedge clk) disable iff (reset)
        (wr_take && latch_mode_bit_reg && in_window(paddr))
        |=> (lat_data_reg == $past(pwdata[7:0])))
        else $error("Latched data not captured");

    a_read_blocked: assert property (@(posedge clk) disable iff (reset)
        (win_rd_wait && latch_mode_bit_reg) |=> (prdata_reg == 32'h0))
        else $error("Array read returned data in latch mode");

    a_normal_read: assert property (@(posedge clk) disable iff (reset)
        (win_rd_wait && !latch_mode_bit_reg)
        |=> (prdata_reg[7:0] == $past(array_rdata)))
        else $error("Array read data wrong");

    a_ctrl_upper_zero: assert property (@(posedge clk) disable iff (reset)
        (rd_setup && paddr == EPC_ADDR_PROGRAM_CONTROL) |=> (prdata_reg[31:2] == 30'h0))
        else $error("Reserved control bits not zero");

    a_ctrl_write: assert property (@(posedge clk) disable iff (reset)
        (wr_take && paddr == EPC_ADDR_PROGRAM_CONTROL)
        |=> (latch_mode_bit_reg == $past(pwdata[EPC_BIT_LATCH])))
        else $error("Control write lost");

    a_boot_entry: assert property (@(posedge clk) disable iff (reset)
        (!reset_seen_reg && tst_sync_reg[1] && pb0_sync_reg[1]) |=> bootloader_mode)
        else $error("Bootloader entry missed");

    // Ready stands for exactly one cycle
    sequence s_ready_pulse;
        pready ##1 !pready;
    endsequence

    a_pready_one: assert property (@(posedge clk) disable iff (reset)
        (setup_phase && !win_rd_setup) |=> s_ready_pulse)
        else $error("Ready not a single cycle");

    a_pready_wait: assert property (@(posedge clk) disable iff (reset)
        win_rd_setup |=> !pready ##1 s_ready_pulse)
        else $error("Array read ready not after one wait");

    a_power_forced: assert property (@(posedge clk) disable iff (reset)
        (wr_take && paddr == EPC_ADDR_PROGRAM_CONTROL && !pwdata[EPC_BIT_LATCH])
        |=> !program_power_bit_reg)
        else $error("Power bit kept without latch bit");

    a_array_power_on: assert property (@(posedge clk) disable iff (reset)
        program_power_bit_reg |-> array_reg.program_power)
        else $error("Array power off while power bit set");

    a_read_path_on: assert property (@(posedge clk) disable iff (reset)
        !latch_mode_bit_reg |-> array_reg.read_enable)
        else $error("Read path closed while latch bit clear");

    a_latch_addr: assert property (@(posedge clk) disable iff (reset)
        (wr_take && latch_mode_bit_reg && in_window(paddr))
        |=> (lat_addr_reg == $past(16'(paddr[EPC_ARRAY_AW-1:0]))))
        else $error("Latched address not captured");

    a_latch_ignored: assert property (@(posedge clk) disable iff (reset)
        (wr_take && !latch_mode_bit_reg && in_window(paddr))
        |=> (lat_data_reg == $past(lat_data_reg)))
        else $error("Array write latched outside latch mode");

    a_boot_stays_off: assert property (@(posedge clk) disable iff (reset)
        (!reset_seen_reg && !(tst_sync_reg[1] && pb0_sync_reg[1])) |=> !bootloader_mode)
        else $error("Bootloader entered without both pins");

    a_boot_timer: assert property (@(posedge clk) disable iff (reset)
        !program_power_bit_reg |=> (boot_cnt_reg == 16'h0000))
        else $error("Byte timer not cleared with power off");

endmodule

`default_nettype wire

// [epc_array_model.sv]
// Behavioural model of the on-chip array behind the programming control block
`timescale 1ns/1ns
`default_nettype none

module epc_array_model
    import epc_pkg::*;
(
    input  wire logic       clk,
    input  wire epc_array_t array_ctl,
    output logic [7:0]      array_rdata
);
    logic [7:0] mem_reg [16];
    logic [7:0] junk_reg = 8'h00;

    // Power with latch set burns the latched byte; junk moves every cycle
    always_ff @(posedge clk) begin
        junk_reg <= junk_reg + 8'h35;
        if (array_ctl.program_power && array_ctl.latch_mode) begin
            mem_reg[array_ctl.addr[3:0]] <= array_ctl.data;
        end
    end

    // A bus not in read mode shows junk, never the last good byte
    assign array_rdata = array_ctl.read_enable ? mem_reg[array_ctl.addr[3:0]] : junk_reg;
endmodule

`default_nettype wire

// [eprom_program_control_tb.sv]
// Self-checking bench for the array programming control block
`timescale 1ns/1ns
`default_nettype none

module eprom_program_control_tb;
    import epc_pkg::*;
    localparam logic [11:0] CTRL = EPC_ADDR_PROGRAM_CONTROL;
    localparam logic [11:0] WIN5 = EPC_ADDR_ARRAY_WINDOW + 12'h005;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        tlv = 1'b0;
    logic        pbz = 1'b0;
    logic        boot;
    logic        rom_sel;
    logic [7:0]  array_rdata;
    epc_array_t  array_ctl;
    int          fail_count = 0;
    int          num_checks = 0;

    epc_program_control dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .test_level_voltage(tlv), .port_b_bit_zero_pin(pbz),
        .array_rdata(array_rdata), .array_ctl(array_ctl), .bootloader_mode(boot),
        .boot_rom_select(rom_sel));
    epc_array_model array_model (.clk(clk), .array_ctl(array_ctl), .array_rdata(array_rdata));

    // Clock at 25 MHz
    initial begin
        forever #20 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Reserved bits and the forced power bit
    task automatic t_fields();
        apb(1'b0, CTRL, 32'h0);
        chk(rd, {24'h0, EPC_CTRL_RESET});
        apb(1'b1, CTRL, 32'hFFFF_FFFD);
        apb(1'b0, CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(array_ctl.program_power, 32'h0);
        apb(1'b1, CTRL, 32'hFFFF_FFFF);
        apb(1'b0, CTRL, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, CTRL, 32'h2);
    endtask

    // Full byte programming order, then read back
    task automatic t_program();
        apb(1'b1, CTRL, 32'h2);
        apb(1'b1, WIN5, 32'h5A);
        chk({array_ctl.latch_mode, array_ctl.addr, array_ctl.data}, 32'h1_0005_5A);
        apb(1'b0, EPC_ADDR_ARRAY_ADDR, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, EPC_ADDR_ARRAY_DATA, 32'h0);
        chk(rd, 32'h5A);
        apb(1'b0, WIN5, 32'h0);
        chk(rd, 32'h0);
        chk(array_ctl.read_enable, 32'h0);
        apb(1'b1, CTRL, 32'h3);
        chk(array_ctl.program_power, 32'h1);
        repeat (EPC_BYTE_PROG_CYCLES) @(posedge clk);
        apb(1'b1, CTRL, 32'h2);
        chk(array_ctl.program_power, 32'h0);
        apb(1'b1, CTRL, 32'h0);
        chk(array_ctl.read_enable, 32'h1);
        apb(1'b1, WIN5, 32'hA5);
        apb(1'b0, WIN5, 32'h0);
        chk(rd, 32'h5A);
    endtask

    // Only the control address reaches the control bits
    task automatic t_decode();
        apb(1'b1, 12'h01C, 32'h2);
        chk(err, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, CTRL, 32'h0);
        chk(err, 32'h0);
        chk(rd, 32'h0);
    endtask

    // Bootloader entry needs both pins at reset release
    task automatic t_boot(input logic t, input logic p);
        @(posedge clk);
        tlv <= t;
        pbz <= p;
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({boot, rom_sel}, {30'h0, t & p, t & p});
        apb(1'b0, EPC_ADDR_STATUS, 32'h0);
        chk(rd[0], t & p);
        // Byte timer in bootloader mode runs while power is on
        if (t & p) begin
            apb(1'b1, CTRL, 32'h2);
            apb(1'b1, CTRL, 32'h3);
            apb(1'b0, EPC_ADDR_STATUS, 32'h0);
            chk(rd[1], 1'b0);
            repeat (EPC_BYTE_PROG_CYCLES) @(posedge clk);
            apb(1'b0, EPC_ADDR_STATUS, 32'h0);
            chk(rd[1], 1'b1);
            apb(1'b1, CTRL, 32'h2);
            apb(1'b1, CTRL, 32'h0);
        end
    endtask

    // Counts, then the verdict
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        tlv <= 1'b1;
        t_fields();
        t_program();
        t_decode();
        for (int i = 0; i < 4; i++) begin
            t_boot(i[1], i[0]);
        end
        print_verdict();
    end

    // Watchdog well beyond the expected run
    initial begin
        #(40 * 80000);
        fail_count++;
        print_verdict();
    end
endmodule

`default_nettype wire
